//--- ppb_port_ctrl.sv
// Added by the designer: the register offsets and the APB slave port.
`timescale 1ns/1ps
`include "ppb_map.svh"
// Summary of operation
// - Requesting device blocks acknowledge; others pass it downstream.
// - Leading edge of acknowledge withdraws the bus interrupt request.
// - Acknowledge raises vector gate, driving vector and bus reply.
// - Vector from switches on address bits 2 to 8, default octal 200.
// - Read of status select gates control/status onto data lines.
// - Data buffer is write-only, loaded only by writes to it.
// - Buffer select when all address bits low; readies pending data.
// - Buffer select with low-byte write makes the load strobe.
// - After a write, demand clocks pending state and starts strobe.
// - Strobe is delayed at least 10 clocks (80 ns) after data lines are presented.
// - Active-low strobe transfers seven data bits plus parity.
// - Printer fault sets error, raising interrupt like completion.
// - Status bits tell completion apart from error interrupts.
// - After error clears, strobing resumes with no initialise.
// - High-byte write to status bit 6 sets or clears enable.
// - Internal request when not busy; bus request only if enabled.
// - Reply given for every addressed strobe and vector transfer.
module ppb_port_ctrl
  import ppb_pkg::*;
#(
  parameter logic [8:0] VEC_SW = `PPB_VEC_DEFAULT
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        bus_init,
  input  wire logic        iack_in,
  output logic             iack_out,
  output logic             irq_out,
  output logic             vector_gate,
  input  wire logic        printer_demand,
  input  wire logic        printer_error,
  output logic [6:0]       char_data,
  output logic             char_parity,
  output logic             char_strobe_n
);
  ppb_state_type st_r;
  ppb_state_type st_nxt;
  logic       irq_enable_bit_r;
  logic [7:0] print_data_buffer_r;
  logic       pending_data_input_r;
  logic       irq_pend_r;
  logic       err_seen_r;
  logic [7:0] stb_cnt_r;
  logic       settle_done;
  logic       ack_edge;
  logic       acc;
  logic       sel_status;
  logic       sel_data;
  logic       sel_vec;
  logic       high_byte_write;
  logic       buffer_load_strobe;
  logic       busy;
  logic       done_bit;
  logic       pending_strobe_state;
  logic       rq_internal;
  logic [15:0] control_status_reg;

  assign acc        = psel && penable;
  assign sel_status = paddr == `PPB_OFF_CSR;
  // Offset 12'h000, all address bits low, selects the buffer
  assign sel_data   = paddr == `PPB_OFF_DATA;
  assign sel_vec    = paddr == `PPB_OFF_VEC;
  assign high_byte_write = acc && pwrite && pstrb[1];
  assign buffer_load_strobe = acc && pwrite && sel_data && pstrb[0];
  assign pready  = 1'b1;
  assign pslverr = acc && !(sel_status || sel_data || sel_vec
                   || paddr == `PPB_OFF_IACK);

  assign busy = st_r != PPB_IDLE;
  assign pending_strobe_state = st_r == PPB_SETTLE || st_r == PPB_STROBE;
  // Fault while waiting counts as done; a committed strobe runs out first
  assign done_bit = !busy ||
    (printer_error && busy && !pending_strobe_state);
  assign rq_internal = done_bit;
  assign irq_out = irq_pend_r && irq_enable_bit_r;

  always_comb begin
    control_status_reg = 16'h0000;
    control_status_reg[`PPB_CSR_ERR_BIT]    = printer_error;
    control_status_reg[`PPB_CSR_ERRIRQ_BIT] = err_seen_r;
    control_status_reg[`PPB_CSR_DONE_BIT]   = !busy;
    control_status_reg[`PPB_CSR_IE_BIT]     = irq_enable_bit_r;
  end

  always_comb begin
    st_nxt = st_r;
    case (st_r)
      PPB_IDLE:   if (buffer_load_strobe) st_nxt = PPB_WAIT;
      // Demand low during error holds here until printer recovers
      PPB_WAIT:   if (printer_demand && !printer_error
                      && pending_data_input_r) begin
        st_nxt = PPB_SETTLE;
      end
      PPB_SETTLE: if (settle_done) st_nxt = PPB_STROBE;
      PPB_STROBE: if (stb_cnt_r == 8'(`PPB_STROBE_CYC - 1)) begin
        st_nxt = PPB_IDLE;
      end
      default:    st_nxt = PPB_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= PPB_IDLE;
      stb_cnt_r <= 8'h00;
    end else if (bus_init) begin
      st_r <= PPB_IDLE;
      stb_cnt_r <= 8'h00;
    end else begin
      st_r <= st_nxt;
      stb_cnt_r <= (st_r == PPB_STROBE) ? stb_cnt_r + 8'h01 : 8'h00;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_enable_bit_r <= 1'b0;
    end else if (bus_init) begin
      irq_enable_bit_r <= 1'b0;
    end else if (high_byte_write && sel_status) begin
      irq_enable_bit_r <= pwdata[`PPB_CSR_IE_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      print_data_buffer_r <= 8'h00;
    end else if (buffer_load_strobe && !busy) begin
      print_data_buffer_r <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pending_data_input_r <= 1'b0;
    end else if (bus_init) begin
      pending_data_input_r <= 1'b0;
    end else if (buffer_load_strobe && !busy) begin
      pending_data_input_r <= 1'b1;
    end else if (st_r == PPB_WAIT && st_nxt == PPB_SETTLE) begin
      pending_data_input_r <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_pend_r <= 1'b0;
      err_seen_r <= 1'b0;
    end else if (bus_init) begin
      irq_pend_r <= 1'b0;
      err_seen_r <= 1'b0;
    end else begin
      if (ack_edge && irq_out) begin
        irq_pend_r <= 1'b0;
      end else if (!rq_internal) begin
        irq_pend_r <= 1'b0;
      end else if (!iack_in) begin
        // Re-arm only once the acknowledge has gone away
        irq_pend_r <= 1'b1;
      end
      if (printer_error) begin
        err_seen_r <= 1'b1;
      end else if (acc && !pwrite && sel_status) begin
        err_seen_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      if (sel_status) begin
        prdata <= {16'h0000, control_status_reg};
      end else if (sel_vec || vector_gate) begin
        prdata <= {23'h000000, VEC_SW[8:2], 2'b00};
      end else begin
        prdata <= 32'h0000_0000;
      end
    end
  end

  assign char_data     = print_data_buffer_r[6:0];
  assign char_parity   = print_data_buffer_r[7];
  assign char_strobe_n = !(st_r == PPB_STROBE);

  ppb_delay #(
    .CYC (`PPB_SETTLE_CYC)
  ) u_settle (
    .pclk    (pclk),
    .presetn (presetn),
    .clr     (bus_init),
    .start   (st_r == PPB_WAIT && st_nxt == PPB_SETTLE),
    .done    (settle_done)
  );

  ppb_iack_chain u_iack (
    .pclk        (pclk),
    .presetn     (presetn),
    .init        (bus_init),
    .req         (irq_out),
    .iack_in     (iack_in),
    .iack_out    (iack_out),
    .vector_gate (vector_gate),
    .ack_edge    (ack_edge)
  );
endmodule // ppb_port_ctrl

//--- ppb_map.svh
`ifndef PPB_MAP_SVH
`define PPB_MAP_SVH
`define PPB_OFF_CSR        12'h004
`define PPB_OFF_DATA       12'h000
`define PPB_OFF_VEC        12'h008
`define PPB_OFF_IACK       12'h00c
`define PPB_CSR_ERR_BIT    15
`define PPB_CSR_DONE_BIT   7
`define PPB_CSR_IE_BIT     6
`define PPB_CSR_ERRIRQ_BIT 8
`define PPB_VEC_DEFAULT    9'h080
`define PPB_SETTLE_NS      75
`define PPB_CLK_NS         8
`define PPB_SETTLE_CYC     ((`PPB_SETTLE_NS + `PPB_CLK_NS - 1) / `PPB_CLK_NS)
`define PPB_STROBE_CYC     2
`endif

//--- ppb_pkg.sv
package ppb_pkg;
  typedef enum logic [1:0] {
    PPB_IDLE   = 2'b00,
    PPB_WAIT   = 2'b01,
    PPB_SETTLE = 2'b10,
    PPB_STROBE = 2'b11
  } ppb_state_type;
endpackage

//--- ppb_delay.sv
`timescale 1ns/1ps
`include "ppb_map.svh"
module ppb_delay
  import ppb_pkg::*;
#(
  parameter int CYC = `PPB_SETTLE_CYC
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic clr,
  input  wire logic start,
  output logic      done
);
  logic [7:0] cnt_r;
  logic       run_r;
  assign done = run_r && (cnt_r == 8'(CYC - 1));
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= 8'h00;
      run_r <= 1'b0;
    end else if (clr || done) begin
      cnt_r <= 8'h00;
      run_r <= 1'b0;
    end else if (start) begin
      cnt_r <= 8'h00;
      run_r <= 1'b1;
    end else if (run_r) begin
      cnt_r <= cnt_r + 8'h01;
    end
  end
endmodule // ppb_delay

//--- ppb_iack_chain.sv
`timescale 1ns/1ps
module ppb_iack_chain
  import ppb_pkg::*;
(
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic init,
  input  wire logic req,
  input  wire logic iack_in,
  output logic      iack_out,
  output logic      vector_gate,
  output logic      ack_edge
);
  logic iack_d_r;
  logic held_r;
  assign ack_edge    = iack_in && !iack_d_r;
  assign vector_gate = iack_in && (held_r || (ack_edge && req));
  // Grant taken once a request is latched keeps blocking to the end
  assign iack_out = iack_in && !(req || held_r);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      iack_d_r <= 1'b0;
      held_r   <= 1'b0;
    end else begin
      iack_d_r <= iack_in;
      if (init || !iack_in) begin
        held_r <= 1'b0;
      end else if (ack_edge && req) begin
        held_r <= 1'b1;
      end
    end
  end
endmodule // ppb_iack_chain

//--- ppb_port_ctrl_asserts.sv
`timescale 1ns/1ps
module ppb_port_ctrl_asserts (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [11:0] paddr,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        bus_init,
  input wire logic        iack_in,
  input wire logic        iack_out,
  input wire logic        irq_out,
  input wire logic        vector_gate,
  input wire logic [6:0]  char_data,
  input wire logic        char_parity,
  input wire logic        char_strobe_n
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_pulse;
    !char_strobe_n ##1 char_strobe_n;
  endsequence
  sequence s_ack;
    $rose(iack_in) && irq_out;
  endsequence
  property p_block;
    vector_gate |-> !iack_out;
  endproperty
  property p_withdraw;
    s_ack |=> !irq_out;
  endproperty
  property p_gate;
    s_ack |-> ##[0:1] vector_gate;
  endproperty
  property p_reply;
    psel && penable |-> pready && (pslverr == !(paddr inside
      {12'h000, 12'h004, 12'h008, 12'h00c}));
  endproperty
  property p_settle;
    $fell(char_strobe_n) |-> char_data == $past(char_data, 10)
      && char_parity == $past(char_parity, 10);
  endproperty
  property p_width;
    $fell(char_strobe_n) |=> s_pulse;
  endproperty
  property p_hold;
    !char_strobe_n |-> $stable({char_parity, char_data});
  endproperty
  property p_init;
    bus_init |=> !irq_out && char_strobe_n;
  endproperty
  property p_busy;
    !char_strobe_n |-> !irq_out;
  endproperty
  a_block: assert property (p_block) else $error("ack passed on");
  a_withdraw: assert property (p_withdraw) else $error("irq kept");
  a_gate: assert property (p_gate) else $error("no vector gate");
  a_reply: assert property (p_reply) else $error("bad reply");
  a_settle: assert property (p_settle) else $error("data moved");
  a_width: assert property (p_width) else $error("strobe width");
  a_hold: assert property (p_hold) else $error("data unstable");
  a_init: assert property (p_init) else $error("init failed");
  a_busy: assert property (p_busy) else $error("irq while busy");
endmodule // ppb_port_ctrl_asserts

//--- ppb_printer_model.sv
`timescale 1ns/1ps
module ppb_printer_model (
  input  wire logic       pclk,
  input  wire logic       fault,
  input  wire logic [3:0] busy_cyc,
  input  wire logic [6:0] char_data,
  input  wire logic       char_parity,
  input  wire logic       char_strobe_n,
  output logic            printer_demand,
  output logic            printer_error,
  output logic [7:0]      got,
  output int              n_got
);
  int busy = 0;
  initial got = 8'h00;
  initial n_got = 0;
  assign printer_error = fault;
  // Not ready while faulted or digesting a character
  assign printer_demand = !fault && busy == 0;
  always @(posedge pclk) begin
    if (!char_strobe_n && busy == 0) begin
      got <= {char_parity, char_data};
      n_got <= n_got + 1;
      busy <= busy_cyc + 2;
    end else if (busy > 0)
      busy <= busy - 1;
  end
endmodule // ppb_printer_model

//--- testbench.sv
`timescale 1ns/1ps
module testbench;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd, seed = 32'h85b6;
  logic [3:0]  pstrb = 4'h0, busy_cyc = 4'h0;
  logic        pready, pslverr, er, bus_init = 0, iack_in = 0, iack_out;
  logic        irq_out, vector_gate, printer_demand, printer_error;
  logic        fault = 0, char_parity, char_strobe_n;
  logic [6:0]  char_data;
  logic [7:0]  got;
  int          n_got, n_mismatch = 0, total_checks = 0;
  bit [7:0]    exp_q[$];
  always #4 pclk = ~pclk;
  ppb_port_ctrl ppb_port_ctrl_i (.*);
  ppb_printer_model ppb_printer_model_i (.*);
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task automatic chk(input logic [31:0] s, e, input string m);
    total_checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d, input logic [3:0] s);
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic send(input logic [7:0] d, input logic f);
    int n;
    n = n_got;
    exp_q.push_back(d);
    fault <= f;
    apb(1, 12'h000, {seed[31:8], d}, 4'h1);
    // Second write lands while busy and must be dropped
    apb(1, 12'h000, {24'h0, ~d}, 4'h1);
    apb(0, 12'h004, 32'h0, 4'h0);
    chk(rd, {16'h0, f, 6'h0, f, 8'h40}, "busy csr");
    chk(irq_out, f, "irq busy");
    fault <= 0;
    for (int i = 0; i < 300 && n_got == n; i++) @(posedge pclk);
    chk(got, exp_q.pop_front(), "char");
    repeat (4) @(posedge pclk);
    chk(n_got - n, 1, "extra char");
    apb(0, 12'h004, 32'h0, 4'h0);
    apb(0, 12'h004, 32'h0, 4'h0);
    chk(rd, 32'hc0, "idle csr");
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1;
    apb(0, 12'h004, 32'h0, 4'h0);
    chk(rd, 32'h80, "csr reset");
    apb(0, 12'h008, 32'h0, 4'h0);
    chk(rd, 32'h80, "vector");
    apb(0, 12'h010, 32'h0, 4'h0);
    chk(rd, 32'h0, "unmapped data");
    chk(er, 1, "unmapped error");
    $display("test registers done");
    apb(1, 12'h004, 32'h40, 4'h2);
    @(posedge pclk);
    chk(irq_out, 1, "irq");
    iack_in <= 1;
    repeat (2) @(posedge pclk);
    chk({vector_gate, iack_out, irq_out}, 3'b100, "ack");
    apb(0, 12'h00c, 32'h0, 4'h0);
    chk(rd, 32'h80, "vector gate");
    iack_in <= 0;
    $display("test interrupt done");
    for (int k = 0; k < 6; k++) begin
      seed = lfsr(seed);
      busy_cyc <= seed[11:8];
      send(seed[7:0], k == 3);
    end
    $display("test transfers done");
    bus_init <= 1;
    @(posedge pclk);
    bus_init <= 0;
    apb(0, 12'h004, 32'h0, 4'h0);
    chk(rd, 32'h80, "init csr");
    chk(irq_out, 0, "init irq");
    iack_in <= 1;
    @(posedge pclk);
    chk({vector_gate, iack_out}, 2'b01, "ack passed");
    iack_in <= 0;
    $display("test init done");
    conclude();
  end
  initial begin
    #200000;
    n_mismatch++;
    conclude();
  end
endmodule // testbench
bind ppb_port_ctrl ppb_port_ctrl_asserts ppb_port_ctrl_asserts_i (.*);
